// file: src/dsp_pkg.sv
// Purpose: constants, types and register map of the priority and pause-source register group
// Assumes: apb with 32-bit data; each byte register sits in the low byte of one aligned word
// Notes: register byte address is four times its index
// How it works
// (R1) a 64-bit table written by software holds one priority bit per type-of-service code point.
// (R2) the top six bits of each ipv4 type-of-service byte form one index that picks one table bit.
// (R3) a picked bit of one means high priority and a picked bit of zero means low priority.
// (R4) the table sits in eight byte registers from index 0x60, highest bits first, each resetting to zero.
// (R5) a 48-bit station address written by software is given out as the pause frame source address.
// (R6) the station address sits in six byte registers from index 0x68, most significant byte first.
// (R7) the three low station address bytes reset to all ones and the three high ones to a fixed prefix.
// (R8) a write to any of these bytes takes effect right after the write completes, with no reset.
package dsp_pkg;

    localparam int DSP_ADDR_W = 12;
    localparam int DSP_DATA_W = 32;
    localparam int DSP_REG_W = 8;
    localparam int DSP_NUM_REGS = 14;
    localparam int DSP_TABLE_REGS = 8;
    localparam int DSP_TABLE_W = 64;
    localparam int DSP_ADDR_BYTES = 6;
    localparam int DSP_STATION_W = 48;
    localparam int DSP_CODE_W = 6;
    localparam int DSP_TOS_W = 8;

    // register indices as printed
    localparam logic [7:0] DSP_IDX_TABLE_FIRST = 8'h60;
    localparam logic [7:0] DSP_IDX_STATION_FIRST = 8'h68;
    localparam logic [7:0] DSP_IDX_LAST = 8'h6D;
    localparam logic [1:0] DSP_WORD_ALIGN = 2'h0;
    localparam int DSP_IDX_LSB = 2;
    localparam int DSP_IDX_MSB = 9;
    // one index per byte register
    localparam logic [7:0] DSP_IDX_PRIO_63_56 = 8'h60;
    localparam logic [7:0] DSP_IDX_PRIO_55_48 = 8'h61;
    localparam logic [7:0] DSP_IDX_PRIO_47_40 = 8'h62;
    localparam logic [7:0] DSP_IDX_PRIO_39_32 = 8'h63;
    localparam logic [7:0] DSP_IDX_PRIO_31_24 = 8'h64;
    localparam logic [7:0] DSP_IDX_PRIO_23_16 = 8'h65;
    localparam logic [7:0] DSP_IDX_PRIO_15_8 = 8'h66;
    localparam logic [7:0] DSP_IDX_PRIO_7_0 = 8'h67;
    localparam logic [7:0] DSP_IDX_STA_BYTE5 = 8'h68;
    localparam logic [7:0] DSP_IDX_STA_BYTE4 = 8'h69;
    localparam logic [7:0] DSP_IDX_STA_BYTE3 = 8'h6A;
    localparam logic [7:0] DSP_IDX_STA_BYTE2 = 8'h6B;
    localparam logic [7:0] DSP_IDX_STA_BYTE1 = 8'h6C;
    localparam logic [7:0] DSP_IDX_STA_BYTE0 = 8'h6D;

    localparam logic [7:0] DSP_TABLE_RST = 8'h00;
    localparam logic [7:0] DSP_STATION_LOW_RST = 8'hFF;

    typedef enum logic [2:0] {
        DSP_ST_IDLE = 3'b001,
        DSP_ST_ACCESS = 3'b010,
        DSP_ST_DONE = 3'b100
    } dsp_apb_state_e;

    typedef struct packed {
        logic valid;
        logic [DSP_TOS_W-1:0] tos;
    } dsp_class_req_s;

    typedef struct packed {
        logic valid;
        logic high;
    } dsp_class_res_s;

endpackage

// file: src/dsp_byte_reg.sv
// Purpose: one software-writable byte register with a fixed reset value
// Assumes: write enable is a one-cycle pulse on the bus clock
// Notes: instantiated once per mapped register
`timescale 1ns/1ps
`default_nettype none
module dsp_byte_reg #(
    parameter logic [7:0] RST_VAL = 8'h00
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] q
);
    logic [7:0] val_r;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            val_r <= RST_VAL;
        end
        else if (we)
        begin
            val_r <= wdata; // (R8)
        end
    end

    assign q = val_r;
endmodule
`default_nettype wire

// file: src/dsp_regs.sv
// Purpose: diffserv priority table, priority classifier and station address over apb
// Assumes: classifier request comes from logic on pclk; apb master follows apb4 signalling
// Notes: zero-wait slave; unmapped or misaligned addresses answer with pslverr
`timescale 1ns/1ps
`default_nettype none
module dsp_regs #(
    // value is arbitrary, stands for the vendor prefix of the station address
    parameter logic [23:0] STATION_PREFIX = 24'h02_4B_3C
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dsp_pkg::DSP_ADDR_W-1:0] paddr,
    input wire logic [dsp_pkg::DSP_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [dsp_pkg::DSP_DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dsp_pkg::dsp_class_req_s class_req,
    output dsp_pkg::dsp_class_res_s class_res,
    output logic [dsp_pkg::DSP_STATION_W-1:0] switch_station_address
);
    import dsp_pkg::*;

    dsp_apb_state_e state_r;
    dsp_apb_state_e state_nxt;
    logic [DSP_DATA_W-1:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [7:0] idx;
    logic hit;
    logic wr_ok;
    logic [DSP_REG_W-1:0] wbyte;
    logic [DSP_REG_W-1:0] rd_byte;
    logic we_prio_63_56;
    logic we_prio_55_48;
    logic we_prio_47_40;
    logic we_prio_39_32;
    logic we_prio_31_24;
    logic we_prio_23_16;
    logic we_prio_15_8;
    logic we_prio_7_0;
    logic we_sta_b5;
    logic we_sta_b4;
    logic we_sta_b3;
    logic we_sta_b2;
    logic we_sta_b1;
    logic we_sta_b0;
    logic [DSP_REG_W-1:0] prio_63_56;
    logic [DSP_REG_W-1:0] prio_55_48;
    logic [DSP_REG_W-1:0] prio_47_40;
    logic [DSP_REG_W-1:0] prio_39_32;
    logic [DSP_REG_W-1:0] prio_31_24;
    logic [DSP_REG_W-1:0] prio_23_16;
    logic [DSP_REG_W-1:0] prio_15_8;
    logic [DSP_REG_W-1:0] prio_7_0;
    logic [DSP_REG_W-1:0] sta_b5;
    logic [DSP_REG_W-1:0] sta_b4;
    logic [DSP_REG_W-1:0] sta_b3;
    logic [DSP_REG_W-1:0] sta_b2;
    logic [DSP_REG_W-1:0] sta_b1;
    logic [DSP_REG_W-1:0] sta_b0;
    logic [DSP_TABLE_W-1:0] table_bits;
    logic [DSP_TABLE_W-1:0] code_onehot;
    dsp_class_res_s res_r;

    // word address: index is the byte address divided by four
    assign idx = paddr[DSP_IDX_MSB:DSP_IDX_LSB];
    assign hit = (paddr[DSP_IDX_LSB-1:0] == DSP_WORD_ALIGN) && (paddr[DSP_ADDR_W-1:DSP_IDX_MSB+1] == '0)
        && (idx >= DSP_IDX_TABLE_FIRST) && (idx <= DSP_IDX_LAST);

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            DSP_ST_IDLE:
            begin
                if (psel && !penable)
                begin
                    state_nxt = DSP_ST_ACCESS;
                end
            end
            DSP_ST_ACCESS:
            begin
                state_nxt = DSP_ST_DONE;
            end
            DSP_ST_DONE:
            begin
                // a setup phase may follow the access phase at once
                state_nxt = (psel && !penable) ? DSP_ST_ACCESS : DSP_ST_IDLE;
            end
            default:
            begin
                state_nxt = DSP_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= DSP_ST_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // answer is prepared at the setup edge so every bus output comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end
        else if (state_nxt == DSP_ST_ACCESS)
        begin
            pready_r <= 1'b1;
            pslverr_r <= !hit;
            prdata_r <= '0;
            if (hit && !pwrite)
            begin
                prdata_r <= {{(DSP_DATA_W-DSP_REG_W){1'b0}}, rd_byte};
            end
        end
        else
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= '0;
        end
    end

    // read mux by index; unmapped indices fall to zero and are refused through hit
    always_comb
    begin
        rd_byte = '0;
        case (idx)
            DSP_IDX_PRIO_63_56: rd_byte = prio_63_56;
            DSP_IDX_PRIO_55_48: rd_byte = prio_55_48;
            DSP_IDX_PRIO_47_40: rd_byte = prio_47_40;
            DSP_IDX_PRIO_39_32: rd_byte = prio_39_32;
            DSP_IDX_PRIO_31_24: rd_byte = prio_31_24;
            DSP_IDX_PRIO_23_16: rd_byte = prio_23_16;
            DSP_IDX_PRIO_15_8: rd_byte = prio_15_8;
            DSP_IDX_PRIO_7_0: rd_byte = prio_7_0;
            DSP_IDX_STA_BYTE5: rd_byte = sta_b5;
            DSP_IDX_STA_BYTE4: rd_byte = sta_b4;
            DSP_IDX_STA_BYTE3: rd_byte = sta_b3;
            DSP_IDX_STA_BYTE2: rd_byte = sta_b2;
            DSP_IDX_STA_BYTE1: rd_byte = sta_b1;
            DSP_IDX_STA_BYTE0: rd_byte = sta_b0;
            default: rd_byte = '0;
        endcase
    end

    // write lands only at the edge that completes the access phase
    assign wr_ok = (state_r == DSP_ST_ACCESS) && psel && penable && pwrite && hit && pstrb[0];
    assign wbyte = pwdata[DSP_REG_W-1:0];
    assign we_prio_63_56 = wr_ok && (idx == DSP_IDX_PRIO_63_56); // (R8)
    assign we_prio_55_48 = wr_ok && (idx == DSP_IDX_PRIO_55_48); // (R8)
    assign we_prio_47_40 = wr_ok && (idx == DSP_IDX_PRIO_47_40); // (R8)
    assign we_prio_39_32 = wr_ok && (idx == DSP_IDX_PRIO_39_32); // (R8)
    assign we_prio_31_24 = wr_ok && (idx == DSP_IDX_PRIO_31_24); // (R8)
    assign we_prio_23_16 = wr_ok && (idx == DSP_IDX_PRIO_23_16); // (R8)
    assign we_prio_15_8 = wr_ok && (idx == DSP_IDX_PRIO_15_8); // (R8)
    assign we_prio_7_0 = wr_ok && (idx == DSP_IDX_PRIO_7_0); // (R8)
    assign we_sta_b5 = wr_ok && (idx == DSP_IDX_STA_BYTE5); // (R8)
    assign we_sta_b4 = wr_ok && (idx == DSP_IDX_STA_BYTE4); // (R8)
    assign we_sta_b3 = wr_ok && (idx == DSP_IDX_STA_BYTE3); // (R8)
    assign we_sta_b2 = wr_ok && (idx == DSP_IDX_STA_BYTE2); // (R8)
    assign we_sta_b1 = wr_ok && (idx == DSP_IDX_STA_BYTE1); // (R8)
    assign we_sta_b0 = wr_ok && (idx == DSP_IDX_STA_BYTE0); // (R8)

    // table bytes all reset to zero, so every code point starts low until software opts in
    dsp_byte_reg #(
        .RST_VAL(DSP_TABLE_RST) // (R4)
    ) u_prio_63_56 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_prio_63_56),
        .wdata(wbyte),
        .q(prio_63_56)
    );

    dsp_byte_reg #(
        .RST_VAL(DSP_TABLE_RST) // (R4)
    ) u_prio_55_48 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_prio_55_48),
        .wdata(wbyte),
        .q(prio_55_48)
    );

    dsp_byte_reg #(
        .RST_VAL(DSP_TABLE_RST) // (R4)
    ) u_prio_47_40 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_prio_47_40),
        .wdata(wbyte),
        .q(prio_47_40)
    );

    dsp_byte_reg #(
        .RST_VAL(DSP_TABLE_RST) // (R4)
    ) u_prio_39_32 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_prio_39_32),
        .wdata(wbyte),
        .q(prio_39_32)
    );

    dsp_byte_reg #(
        .RST_VAL(DSP_TABLE_RST) // (R4)
    ) u_prio_31_24 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_prio_31_24),
        .wdata(wbyte),
        .q(prio_31_24)
    );

    dsp_byte_reg #(
        .RST_VAL(DSP_TABLE_RST) // (R4)
    ) u_prio_23_16 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_prio_23_16),
        .wdata(wbyte),
        .q(prio_23_16)
    );

    dsp_byte_reg #(
        .RST_VAL(DSP_TABLE_RST) // (R4)
    ) u_prio_15_8 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_prio_15_8),
        .wdata(wbyte),
        .q(prio_15_8)
    );

    dsp_byte_reg #(
        .RST_VAL(DSP_TABLE_RST) // (R4)
    ) u_prio_7_0 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_prio_7_0),
        .wdata(wbyte),
        .q(prio_7_0)
    );

    // station bytes, most significant first; the high three carry the prefix, the rest all ones
    dsp_byte_reg #(
        .RST_VAL(STATION_PREFIX[3*DSP_REG_W-1 -: DSP_REG_W]) // (R7)
    ) u_sta_b5 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_sta_b5),
        .wdata(wbyte),
        .q(sta_b5)
    );

    dsp_byte_reg #(
        .RST_VAL(STATION_PREFIX[2*DSP_REG_W-1 -: DSP_REG_W]) // (R7)
    ) u_sta_b4 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_sta_b4),
        .wdata(wbyte),
        .q(sta_b4)
    );

    dsp_byte_reg #(
        .RST_VAL(STATION_PREFIX[DSP_REG_W-1:0]) // (R7)
    ) u_sta_b3 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_sta_b3),
        .wdata(wbyte),
        .q(sta_b3)
    );

    dsp_byte_reg #(
        .RST_VAL(DSP_STATION_LOW_RST) // (R7)
    ) u_sta_b2 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_sta_b2),
        .wdata(wbyte),
        .q(sta_b2)
    );

    dsp_byte_reg #(
        .RST_VAL(DSP_STATION_LOW_RST) // (R7)
    ) u_sta_b1 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_sta_b1),
        .wdata(wbyte),
        .q(sta_b1)
    );

    dsp_byte_reg #(
        .RST_VAL(DSP_STATION_LOW_RST) // (R7)
    ) u_sta_b0 (
        .pclk(pclk),
        .presetn(presetn),
        .we(we_sta_b0),
        .wdata(wbyte),
        .q(sta_b0)
    );

    // lowest index holds the highest table bits
    assign table_bits = {prio_63_56, prio_55_48, prio_47_40, prio_39_32, // (R1) (R4)
        prio_31_24, prio_23_16, prio_15_8, prio_7_0};
    // pause frames see the address straight from the register flops, no shadow copy
    assign switch_station_address = {sta_b5, sta_b4, sta_b3, sta_b2, sta_b1, sta_b0}; // (R5) (R6)

    // full decode into one-hot, then a single bit survives the mask
    always_comb
    begin
        code_onehot = '0;
        code_onehot[class_req.tos[DSP_TOS_W-1 -: DSP_CODE_W]] = 1'b1; // (R2)
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            res_r <= '0;
        end
        else
        begin
            res_r.valid <= class_req.valid;
            res_r.high <= class_req.valid && |(code_onehot & table_bits); // (R3)
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign class_res = res_r;
endmodule
`default_nettype wire

// file: tb/dsp_regs_properties.sv
// Purpose: bus and classifier timing checks for dsp_regs
// Assumes: zero-wait apb slave, classifier answer one cycle after request
// Notes: bound to every dsp_regs instance
`timescale 1ns/1ps
`default_nettype none
module dsp_regs_properties (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dsp_pkg::DSP_ADDR_W-1:0] paddr,
    input wire logic [dsp_pkg::DSP_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [dsp_pkg::DSP_DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire dsp_pkg::dsp_class_req_s class_req,
    input wire dsp_pkg::dsp_class_res_s class_res,
    input wire logic [dsp_pkg::DSP_STATION_W-1:0] switch_station_address
);
    import dsp_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RDY: assert property (psel && !penable |=> pready) else $error("no ready after setup");
    AST_PULSE: assert property (pready |=> !pready) else $error("ready held too long");
    AST_IDLE: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("bus outputs not idle");
    AST_UPPER: assert property (pready |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
    AST_ANS: assert property (class_req.valid |=> class_res.valid) else $error("no classifier answer");
    AST_QUIET: assert property (!class_req.valid |=> class_res == '0) else $error("answer without request");
    AST_STA: assert property (psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h1B4
        |=> switch_station_address[7:0] == $past(pwdata[7:0])) else $error("station byte not stored");
    // outside reset the address may only move on a completed write, so nothing else can disturb pause frames
    AST_HOLD: assert property (!(psel && penable && pready && pwrite) |=> $stable(switch_station_address))
        else $error("station address moved");
endmodule
bind dsp_regs dsp_regs_properties chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .class_req, .class_res, .switch_station_address);
`default_nettype wire

// file: tb/tb_diffserv_priority_and_pause_source.sv
// Purpose: register map, reset values and classifier of dsp_regs
// Assumes: apb master leaves one idle cycle between transfers unless a call chains the next setup
// Notes: table pattern gives each of the eight table byte registers a different value
`timescale 1ns/1ps
`default_nettype none
module tb_diffserv_priority_and_pause_source;
    import dsp_pkg::*;
    localparam logic [23:0] PFX = 24'h5A6C3E; // arbitrary prefix value
    localparam logic [63:0] TBL = 64'hF0E1D2C3B4A59687;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic [3:0] pstrb = 4'hF;
    dsp_class_req_s class_req = '0;
    dsp_class_res_s class_res;
    logic [47:0] switch_station_address;
    int miscompares = 0, checked = 0;
    dsp_regs #(.STATION_PREFIX(PFX)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .class_req, .class_res, .switch_station_address);
    initial forever #4 pclk = ~pclk;
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // idle edge at the end keeps psel from being lowered and raised in one step
    // keep leaves psel up so the next call's setup follows at once; the wait for pready has no limit, only the watchdog ends a hung one
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d, input bit keep = 1'b0);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        if (!keep)
        begin
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task automatic cls(input logic [5:0] c, input logic x);
        class_req <= '{1'b1, {c, 2'b10}};
        @(posedge pclk);
        class_req <= '0;
        @(posedge pclk);
        chk(64'(class_res), {62'h0, 1'b1, x});
    endtask
    function automatic logic [7:0] rst_val(int i);
        return i < 8 ? 8'h00 : i < 11 ? PFX[23 - 8 * (i - 8) -: 8] : 8'hFF;
    endfunction
    initial
    begin
        #20000;
        miscompares++;
        close_out;
    end
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(64'(switch_station_address), {16'h0, PFX, 24'hFFFFFF});
        for (int i = 0; i < 14; i++)
        begin
            apb(1'b0, 12'h180 + 12'(4 * i), 8'h00);
            chk(64'({e, q}), 64'(rst_val(i)));
        end
        $display("reset values done");
        for (int i = 0; i < 8; i++)
            apb(1'b1, 12'h180 + 12'(4 * i), TBL[63 - 8 * i -: 8]);
        for (int i = 0; i < 6; i++)
            apb(1'b1, 12'h1A0 + 12'(4 * i), 8'(8'h11 * (i + 1)));
        chk(64'(switch_station_address), 64'h112233445566);
        apb(1'b0, 12'h184, 8'h00);
        chk(64'({e, q}), 64'(TBL[55:48]));
        apb(1'b1, 12'h1A0, 8'hA5, 1'b1);
        apb(1'b0, 12'h1A0, 8'h00);
        chk(64'({e, q}), 64'hA5);
        chk(64'(switch_station_address[47:40]), 64'hA5);
        for (int c = 0; c < 64; c++)
            cls(6'(c), TBL[c]);
        apb(1'b1, 12'h19C, 8'h00);
        cls(6'h00, 1'b0);
        $display("table and station done");
        apb(1'b1, 12'h1B8, 8'h77);
        chk(64'({e, q}), 64'h100000000);
        apb(1'b0, 12'h181, 8'h00);
        chk(64'({e, q}), 64'h100000000);
        apb(1'b0, 12'h580, 8'h00);
        chk(64'({e, q}), 64'h100000000);
        pstrb <= 4'h0;
        apb(1'b1, 12'h1B4, 8'hEE);
        pstrb <= 4'hF;
        chk(64'(switch_station_address[7:0]), 64'h66);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk(64'(switch_station_address), {16'h0, PFX, 24'hFFFFFF});
        cls(6'h3F, 1'b0);
        $display("refusals and reset done");
        close_out;
    end
endmodule
`default_nettype wire
